// [pkg/pcg_pkg.sv]
// Constants, register map and bus carriers for the peripheral clock gating block
package pcg_pkg;
	// Bus widths
	localparam int PCG_ADDR_W = 8;
	localparam int PCG_DATA_W = 32;
	localparam int PCG_NUM_PERIPH = 16;

	// Register byte addresses
	localparam logic [7:0] PCG_OFF_GATE_ZERO = 8'h00;
	localparam logic [7:0] PCG_OFF_GATE_ONE = 8'h04;
	localparam logic [7:0] PCG_OFF_TMR_CMP = 8'h08;
	localparam logic [7:0] PCG_OFF_CAP_TMR_HI = 8'h0c;
	localparam logic [7:0] PCG_OFF_FUNC_EN = 8'h10;

	// Register index from decode
	localparam logic [2:0] PCG_IDX_GATE_ZERO = 3'h0;
	localparam logic [2:0] PCG_IDX_GATE_ONE = 3'h1;
	localparam logic [2:0] PCG_IDX_TMR_CMP = 3'h2;
	localparam logic [2:0] PCG_IDX_CAP_TMR_HI = 3'h3;
	localparam logic [2:0] PCG_IDX_FUNC_EN = 3'h4;
	localparam logic [2:0] PCG_IDX_NONE = 3'h7;

	// Reset values
	localparam logic [7:0] PCG_GATE_RESET = 8'h00;
	localparam logic [15:0] PCG_FUNC_EN_RESET = 16'h0000;

	// Implemented bits: full and small program memory variants
	localparam logic [7:0] PCG_MASK_FULL = 8'hff;
	localparam logic [7:0] PCG_MASK_TMR_CMP_SMALL = 8'h5f;
	localparam logic [7:0] PCG_MASK_CAP_TMR_SMALL = 8'h3e;

	// Peripheral vector layout: low byte timer/comparator, high byte capture/timer
	localparam int PCG_POS_TMR_CMP = 0;
	localparam int PCG_POS_CAP_TMR = 8;

	// Responses
	localparam logic [1:0] PCG_RESP_OKAY = 2'h0;
	localparam logic [1:0] PCG_RESP_SLVERR = 2'h2;

	// Master to slave
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} pcg_axil_req_s;

	// Slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pcg_axil_rsp_s;
endpackage

// [logic/pcg_clock_gate.sv]
// Glitch-free clock gate cell for one peripheral
`timescale 1ns/100ps
`default_nettype none
module pcg_clock_gate (
	// Clock and reset
	input wire logic clk,
	input wire logic aresetn,
	// Control
	input wire logic gate_off,
	// Gated clock
	output logic gated_clk
);
	logic enable;

	// Enable changes only while the clock is low, so no runt pulse
	always_ff @(negedge clk) begin
		if (!aresetn) begin
			enable <= 1'b1;
		end else begin
			enable <= ~gate_off;
		end
	end

	// Clock passes only with a settled enable
	assign gated_clk = clk & enable;
endmodule
`default_nettype wire

// [logic/pcg_top.sv]
// Peripheral clock gating: AXI4-Lite register file, clock gates and access freeze
//
// Summary of operation
// - Each peripheral has separate functional enable bit.
// - Enable clear stops peripheral, registers stay accessible.
// - Disable bit set gates that peripheral's clock.
// - Gated peripheral ignores writes, reads invalid.
// - Four 8-bit gate registers, reset zero.
// - Capture/timer register: capture 10..4, timer 12.
// - Timer/comparator register: timers then comparators.
// - Small variant: some bits unimplemented, read zero.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pcg_top #(
	parameter bit SMALL_MEMORY = 1'b0,
	parameter int NUM_PERIPH = pcg_pkg::PCG_NUM_PERIPH
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire pcg_pkg::pcg_axil_req_s axil_req,
	output pcg_pkg::pcg_axil_rsp_s axil_rsp,
	// Peripheral clocks and status
	output logic [NUM_PERIPH-1:0] periph_clk,
	output logic [NUM_PERIPH-1:0] periph_gate_off,
	output logic [NUM_PERIPH-1:0] periph_run,
	// Peripheral register access
	input wire logic [NUM_PERIPH-1:0] periph_wr_req,
	input wire logic [NUM_PERIPH-1:0] periph_rd_req,
	output logic [NUM_PERIPH-1:0] periph_wr_en,
	output logic [NUM_PERIPH-1:0] periph_rd_valid
);
	import pcg_pkg::*;

	// Implemented bits for this variant
	localparam logic [7:0] MASK_TMR_CMP = SMALL_MEMORY ? PCG_MASK_TMR_CMP_SMALL : PCG_MASK_FULL;
	localparam logic [7:0] MASK_CAP_TMR = SMALL_MEMORY ? PCG_MASK_CAP_TMR_SMALL : PCG_MASK_FULL;

	// Address to register index
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		case (addr)
			PCG_OFF_GATE_ZERO: reg_index = PCG_IDX_GATE_ZERO;
			PCG_OFF_GATE_ONE: reg_index = PCG_IDX_GATE_ONE;
			PCG_OFF_TMR_CMP: reg_index = PCG_IDX_TMR_CMP;
			PCG_OFF_CAP_TMR_HI: reg_index = PCG_IDX_CAP_TMR_HI;
			PCG_OFF_FUNC_EN: reg_index = PCG_IDX_FUNC_EN;
			default: reg_index = PCG_IDX_NONE;
		endcase
	endfunction

	// Register state
	logic [7:0] gate_register_zero;
	logic [7:0] gate_register_one;
	logic [7:0] timer_comparator_gate_ctl;
	logic [7:0] capture_timer_gate_ctl_hi;
	logic [15:0] module_function_enable;
	logic [7:0] next_gate_register_zero;
	logic [7:0] next_gate_register_one;
	logic [7:0] next_timer_comparator_gate_ctl;
	logic [7:0] next_capture_timer_gate_ctl_hi;
	logic [15:0] next_module_function_enable;

	// Write channel state
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic [7:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic bvalid;
	logic [1:0] bresp;
	logic next_bvalid;
	logic [1:0] next_bresp;

	// Read channel state
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// Peripheral side state
	logic [NUM_PERIPH-1:0] next_periph_run;
	logic [NUM_PERIPH-1:0] next_periph_wr_en;
	logic [NUM_PERIPH-1:0] next_periph_rd_valid;
	logic [NUM_PERIPH-1:0] gate_vec;

	logic aw_take;
	logic w_take;
	logic do_write;
	logic ar_take;
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;

	// Handshakes
	assign aw_take = axil_req.awvalid & ~aw_held & ~bvalid;
	assign w_take = axil_req.wvalid & ~w_held & ~bvalid;
	assign do_write = aw_held & w_held & ~bvalid;
	assign ar_take = axil_req.arvalid & ~rvalid;
	assign wr_idx = reg_index(aw_addr);
	assign rd_idx = reg_index(axil_req.araddr);

	// Gate vector: timer/comparator low byte, capture/timer high byte
	assign gate_vec = {capture_timer_gate_ctl_hi, timer_comparator_gate_ctl};

	// Write address and data capture, response
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (aw_take) begin
			next_aw_held = 1'b1;
			next_aw_addr = axil_req.awaddr;
		end
		if (w_take) begin
			next_w_held = 1'b1;
			next_w_data = axil_req.wdata;
			next_w_strb = axil_req.wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wr_idx == PCG_IDX_NONE) ? PCG_RESP_SLVERR : PCG_RESP_OKAY;
		end else if (bvalid && axil_req.bready) begin
			next_bvalid = 1'b0;
		end
	end

	// Register writes; unimplemented bits never store
	always_comb begin
		next_gate_register_zero = gate_register_zero;
		next_gate_register_one = gate_register_one;
		next_timer_comparator_gate_ctl = timer_comparator_gate_ctl;
		next_capture_timer_gate_ctl_hi = capture_timer_gate_ctl_hi;
		next_module_function_enable = module_function_enable;
		if (do_write) begin
			case (wr_idx)
				PCG_IDX_GATE_ZERO: begin
					if (w_strb[0]) begin
						next_gate_register_zero = w_data[7:0];
					end
				end
				PCG_IDX_GATE_ONE: begin
					if (w_strb[0]) begin
						next_gate_register_one = w_data[7:0];
					end
				end
				PCG_IDX_TMR_CMP: begin
					if (w_strb[0]) begin
						next_timer_comparator_gate_ctl = w_data[7:0] & MASK_TMR_CMP;
					end
				end
				PCG_IDX_CAP_TMR_HI: begin
					if (w_strb[0]) begin
						next_capture_timer_gate_ctl_hi = w_data[7:0] & MASK_CAP_TMR;
					end
				end
				PCG_IDX_FUNC_EN: begin
					if (w_strb[0]) begin
						next_module_function_enable[7:0] = w_data[7:0];
					end
					if (w_strb[1]) begin
						next_module_function_enable[15:8] = w_data[15:8];
					end
				end
				default: begin
					next_module_function_enable = module_function_enable;
				end
			endcase
		end
	end

	// Read channel: one cycle after address is taken
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (ar_take) begin
			next_rvalid = 1'b1;
			next_rresp = PCG_RESP_OKAY;
			case (rd_idx)
				PCG_IDX_GATE_ZERO: next_rdata = {24'h000000, gate_register_zero};
				PCG_IDX_GATE_ONE: next_rdata = {24'h000000, gate_register_one};
				PCG_IDX_TMR_CMP: next_rdata = {24'h000000, timer_comparator_gate_ctl};
				PCG_IDX_CAP_TMR_HI: next_rdata = {24'h000000, capture_timer_gate_ctl_hi};
				PCG_IDX_FUNC_EN: next_rdata = {16'h0000, module_function_enable};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = PCG_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && axil_req.rready) begin
			next_rvalid = 1'b0;
		end
	end

	// Peripheral run and register access freeze
	always_comb begin
		next_periph_run = module_function_enable[NUM_PERIPH-1:0] & ~gate_vec;
		next_periph_wr_en = periph_wr_req & ~gate_vec;
		next_periph_rd_valid = periph_rd_req & ~gate_vec;
	end

	// State registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_register_zero <= PCG_GATE_RESET;
			gate_register_one <= PCG_GATE_RESET;
			timer_comparator_gate_ctl <= PCG_GATE_RESET;
			capture_timer_gate_ctl_hi <= PCG_GATE_RESET;
			module_function_enable <= PCG_FUNC_EN_RESET;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= PCG_RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= PCG_RESP_OKAY;
			periph_run <= '0;
			periph_wr_en <= '0;
			periph_rd_valid <= '0;
		end else begin
			gate_register_zero <= next_gate_register_zero;
			gate_register_one <= next_gate_register_one;
			timer_comparator_gate_ctl <= next_timer_comparator_gate_ctl;
			capture_timer_gate_ctl_hi <= next_capture_timer_gate_ctl_hi;
			module_function_enable <= next_module_function_enable;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			periph_run <= next_periph_run;
			periph_wr_en <= next_periph_wr_en;
			periph_rd_valid <= next_periph_rd_valid;
		end
	end

	// Bus answer
	always_comb begin
		axil_rsp.awready = ~aw_held & ~bvalid;
		axil_rsp.wready = ~w_held & ~bvalid;
		axil_rsp.bvalid = bvalid;
		axil_rsp.bresp = bresp;
		axil_rsp.arready = ~rvalid;
		axil_rsp.rvalid = rvalid;
		axil_rsp.rdata = rdata;
		axil_rsp.rresp = rresp;
	end

	// Gate flags come straight from the gate registers
	assign periph_gate_off = gate_vec;

	// One glitch-free gate per peripheral
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_gate
			pcg_clock_gate u_gate (
				.clk(aclk),
				.aresetn(aresetn),
				.gate_off(gate_vec[gi]),
				.gated_clk(periph_clk[gi])
			);
		end
	endgenerate

	// Checks
	write_lands_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && wr_idx == PCG_IDX_TMR_CMP && w_strb[0]
		|=> timer_comparator_gate_ctl == ($past(w_data[7:0]) & MASK_TMR_CMP))
		else $error("timer comparator write not stored");
	cap_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && wr_idx == PCG_IDX_CAP_TMR_HI && w_strb[0]
		|=> capture_timer_gate_ctl_hi == ($past(w_data[7:0]) & MASK_CAP_TMR))
		else $error("capture timer write not stored");
	small_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		SMALL_MEMORY |-> (capture_timer_gate_ctl_hi & ~PCG_MASK_CAP_TMR_SMALL) == 8'h00
		&& (timer_comparator_gate_ctl & ~PCG_MASK_TMR_CMP_SMALL) == 8'h00)
		else $error("unimplemented bit set");
	reset_clear_a: assert property (@(posedge aclk)
		!aresetn |=> gate_vec == '0 && gate_register_zero == 8'h00 && gate_register_one == 8'h00)
		else $error("gate register not cleared by reset");
	frozen_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		gate_vec[0] && $stable(gate_vec[0]) |-> !periph_wr_en[0])
		else $error("write passed to gated peripheral");
	enable_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!module_function_enable[0] |=> !periph_run[0])
		else $error("peripheral runs with enable clear");
	open_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		periph_rd_req[0] && !gate_vec[0] |=> periph_rd_valid[0])
		else $error("read refused while clocked");
	clock_stop_a: assert property (@(negedge aclk) disable iff (!aresetn)
		gate_vec[1] ##1 gate_vec[1] |-> !periph_clk[1])
		else $error("clock runs while gated");
	read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_take |=> rvalid
		&& rresp == (($past(rd_idx) == PCG_IDX_NONE) ? PCG_RESP_SLVERR : PCG_RESP_OKAY))
		else $error("read not answered in one cycle");
	bresp_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && wr_idx == PCG_IDX_NONE |=> bvalid && bresp == PCG_RESP_SLVERR)
		else $error("unmapped write not refused");
endmodule
`default_nettype wire

// [testbench/pcg_periph_model.sv]
// Model of the gated peripherals: edge counters and access requests
`timescale 1ns/100ps
`default_nettype none
module pcg_periph_model (
	// Clock
	input wire logic aclk,
	// Gated clocks from the block
	input wire logic [15:0] periph_clk,
	// Access commands from the bench
	input wire logic [15:0] wr_cmd,
	input wire logic [15:0] rd_cmd,
	// Register requests toward the block
	output logic [15:0] periph_wr_req,
	output logic [15:0] periph_rd_req
);
	int unsigned cnt [16] = '{default: 0};
	// Idle requests at time zero
	initial begin
		periph_wr_req = '0;
		periph_rd_req = '0;
	end
	// Requests launched on the system clock, one register for all units
	always @(posedge aclk) begin
		periph_wr_req <= wr_cmd;
		periph_rd_req <= rd_cmd;
	end
	// Each unit counts the edges it really receives
	for (genvar i = 0; i < 16; i++) begin : g_unit
		always @(posedge periph_clk[i]) begin
			cnt[i] <= cnt[i] + 1;
		end
	end
endmodule
`default_nettype wire

// [testbench/peripheral_clock_gating_tb_top.sv]
// Self-checking bench for the peripheral clock gating block
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gating_tb_top;
	import pcg_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	pcg_axil_req_s req = '0;
	pcg_axil_rsp_s rsp;
	pcg_axil_rsp_s rsp_s;
	logic [15:0] p_clk, gate_off, gate_s, run, wr_req, rd_req, wr_en, rd_valid;
	logic [15:0] wr_cmd = '0;
	logic [15:0] rd_cmd = '0;
	logic [31:0] d, rd_s;
	logic [1:0] r;
	int err_total = 0;
	int samples_checked = 0;
	int unsigned c0 [16];
	// 25 MHz system clock
	always #20 aclk = ~aclk;
	pcg_top dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .periph_clk(p_clk),
		.periph_gate_off(gate_off), .periph_run(run), .periph_wr_req(wr_req), .periph_rd_req(rd_req),
		.periph_wr_en(wr_en), .periph_rd_valid(rd_valid));
	// Small memory variant listening to the same bus
	pcg_top #(.SMALL_MEMORY(1'b1)) dut_small (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
		.axil_rsp(rsp_s), .periph_clk(), .periph_gate_off(gate_s), .periph_run(),
		.periph_wr_req(wr_req), .periph_rd_req(rd_req), .periph_wr_en(), .periph_rd_valid());
	pcg_periph_model partner (.aclk(aclk), .periph_clk(p_clk), .wr_cmd(wr_cmd), .rd_cmd(rd_cmd),
		.periph_wr_req(wr_req), .periph_rd_req(rd_req));
	// Compare and count
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Bus write, address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask
	// Bus read, both variants captured
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		rd_s = rsp_s.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask
	// Ten system cycles: gated units see no edge, others see ten
	task automatic clk_win(input logic [15:0] g);
		@(posedge aclk);
		#1;
		c0 = partner.cnt;
		repeat (10) @(posedge aclk);
		#1;
		for (int i = 0; i < 16; i++) chk("edges", partner.cnt[i] - c0[i], g[i] ? 0 : 10);
	endtask
	// Register access from the units under a given gate pattern
	task automatic acc(input logic [15:0] m, input logic [15:0] g);
		@(posedge aclk);
		wr_cmd <= m;
		rd_cmd <= m;
		repeat (3) @(posedge aclk);
		#1;
		chk("wr_en", wr_en, m & ~g);
		chk("rd_valid", rd_valid, m & ~g);
		@(posedge aclk);
		wr_cmd <= '0;
		rd_cmd <= '0;
	endtask
	// Counts and verdict
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		print_verdict();
	end
	// Test sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			axr(8'(i * 4));
			chk("reset", d, 32'h0);
		end
		chk("gate_off", gate_off, 16'h0);
		clk_win(16'h0);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			axw(8'(i * 4), 32'h1234_56a5);
			axr(8'(i * 4));
			chk("gate_low", d, 32'ha5);
		end
		for (int k = 0; k < 8; k++) begin
			axw(PCG_OFF_TMR_CMP, 32'h1 << k);
			axw(PCG_OFF_CAP_TMR_HI, 32'hffff_ff00 | (32'h80 >> k));
			axr(PCG_OFF_CAP_TMR_HI);
			chk("cap_timer", d, 32'h80 >> k);
			chk("gate_off", gate_off, {8'h80 >> k, 8'h01 << k});
			clk_win({8'h80 >> k, 8'h01 << k});
		end
		$display("test mapping done");
		axw(PCG_OFF_TMR_CMP, 32'hff);
		axw(PCG_OFF_CAP_TMR_HI, 32'hff);
		axr(PCG_OFF_TMR_CMP);
		chk("full_tc", d, 32'hff);
		chk("small_tc", rd_s, 32'h5f);
		axr(PCG_OFF_CAP_TMR_HI);
		chk("small_ct", rd_s, 32'h3e);
		chk("small_gate", gate_s, 16'h3e5f);
		acc(16'hffff, 16'hffff);
		axw(PCG_OFF_CAP_TMR_HI, 32'h0);
		axw(PCG_OFF_TMR_CMP, 32'h0f);
		clk_win(16'h000f);
		acc(16'h00ff, 16'h000f);
		$display("test gating done");
		axw(PCG_OFF_FUNC_EN, 32'h0000_a5ff);
		axr(PCG_OFF_FUNC_EN);
		#1;
		chk("func_en", d, 32'ha5ff);
		chk("run", run, 16'ha5f0);
		acc(16'hff00, 16'h000f);
		clk_win(16'h000f);
		axw(8'h20, 32'h1);
		chk("bresp", r, PCG_RESP_SLVERR);
		axr(8'h20);
		chk("rresp", r, PCG_RESP_SLVERR);
		chk("rdata", d, 32'h0);
		$display("test enable done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		chk("gate_off", gate_off, 16'h0);
		chk("run", run, 16'h0);
		$display("test second reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
